// [hw/urbg_frac_div.sv]
`timescale 1ns/1ns
`include "urbg_consts.svh"

module urbg_frac_div
	import urbg_pkg::*;
(
	// clock and reset
	input  wire logic           i_clk,
	input  wire logic           i_sys_rst,
	// setup
	input  wire urbg_baud_cfg_t i_cfg,
	// ticks
	output logic                o_sample_tick,
	output logic                o_bit_tick
);

	logic [1:0]  pre_cnt;
	logic        pre_tick;
	logic [19:0] div16;
	logic [20:0] acc;
	logic [20:0] acc_sum;
	logic [4:0]  osr_cnt;
	logic [4:0]  osr_top;

	// prescaler tick every cycle or every fourth
	assign pre_tick = !i_cfg.prescale_div4 || (pre_cnt == `URBG_PRESCALE_LAST);

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			pre_cnt <= 2'h0;
		else if (pre_tick)
			pre_cnt <= 2'h0;
		else
			pre_cnt <= pre_cnt + 2'h1;
	end

	// divisor in sixteenths; integer zero is clamped to one
	assign div16   = (i_cfg.integer_part == 16'h0000) ? `URBG_DIV16_MIN
	                 : {i_cfg.integer_part, i_cfg.fraction};
	assign acc_sum = acc + `URBG_FRAC_ONE;

	// phase accumulator; tick spacing alternates, so bits jitter by 1/16
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			acc           <= 21'h000000;
			o_sample_tick <= 1'b0;
		end
		else if (pre_tick && (acc_sum >= {1'b0, div16}))
		begin
			// a divisor cut below the running phase restarts it, else ticks would burst
			if (acc >= {1'b0, div16})
				acc <= 21'h000000;
			else
				acc <= acc_sum - {1'b0, div16};
			o_sample_tick <= 1'b1;
		end
		else
		begin
			if (pre_tick)
				acc <= acc_sum;
			o_sample_tick <= 1'b0;
		end
	end

	// bit tick once per 16, 8 or 4 sample ticks
	assign osr_top = urbg_osr_ticks(i_cfg.osr_sel);

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			osr_cnt    <= 5'h00;
			o_bit_tick <= 1'b0;
		end
		else if (o_sample_tick && (osr_cnt + 5'h01 >= osr_top))
		begin
			osr_cnt    <= 5'h00;
			o_bit_tick <= 1'b1;
		end
		else
		begin
			if (o_sample_tick)
				osr_cnt <= osr_cnt + 5'h01;
			o_bit_tick <= 1'b0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_prescale_div4;
		// software may drop back to divide-by-1 at any point
		(i_cfg.prescale_div4 && pre_tick) |=> (!pre_tick || !i_cfg.prescale_div4) [*3];
	endproperty
	a_prescale_div4: assert property (p_prescale_div4)
		else $error("divide-by-4 prescaler ticked early");

	property p_div_one;
		(div16 == `URBG_DIV16_MIN && !i_cfg.prescale_div4 && $stable(div16)) |=> o_sample_tick;
	endproperty
	a_div_one: assert property (p_div_one)
		else $error("divisor of one did not tick every cycle");

endmodule // urbg_frac_div

// [hw/urbg_status_baud.sv]
`timescale 1ns/1ns
`include "urbg_consts.svh"


module urbg_status_baud
	import urbg_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
)
(
	// clock and reset
	input  wire logic            i_clk,
	input  wire logic            i_sys_rst,
	// host register port
	input  wire logic            i_bus_cs,
	input  wire logic            i_bus_wr,
	input  wire logic            i_bus_rd,
	input  wire logic [2:0]      i_bus_addr,
	input  wire logic [7:0]      i_bus_wdata,
	input  wire logic            i_div_latch_en,
	output logic      [7:0]      o_bus_rdata,
	// strap
	input  wire logic            i_prescale_default_select,
	// fifo status from the channel
	input  wire urbg_fifo_stat_t i_fifo_stat,
	input  wire logic            i_rx_char_pulse,
	input  wire logic            i_rx_read_pulse,
	// status pins and mode
	output urbg_pins_t           o_pins,
	output logic                 o_rx_timeout,
	output logic                 o_fifo_enable,
	output logic                 o_block_mode,
	// serial timing
	output logic                 o_sample_tick,
	output logic                 o_bit_tick
);

	logic [7:0]             div_low;
	logic [7:0]             div_high;
	logic [7:0]             div_frac;
	logic [7:0]             fifo_ctrl;
	logic [7:0]             modem_ctrl;
	logic                   strap_taken;
	logic                   wr_strobe;
	logic                   rd_strobe;
	logic                   fifo_en;
	logic                   block_en;
	logic                   rx_has_data;
	logic                   rx_at_trig;
	logic                   tx_full;
	logic                   to_armed;
	logic [5:0]             to_cnt;
	urbg_rdy_state_t        rdy_state;
	urbg_rdy_state_t        next_rdy_state;
	urbg_pins_t             next_pins;
	urbg_baud_cfg_t         baud_cfg;

	// host strobes qualified by chip select only
	assign wr_strobe = i_bus_cs && i_bus_wr;
	assign rd_strobe = i_bus_cs && i_bus_rd;

	// divisor registers, shown only while the latch enable is set
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			div_low  <= `URBG_RST_DIV_LOW;
			div_high <= `URBG_RST_DIV_HIGH;
			div_frac <= `URBG_RST_DIV_FRAC;
		end
		else if (wr_strobe && i_div_latch_en)
		begin
			if (i_bus_addr == `URBG_OFS_DIV_LOW)
				div_low <= i_bus_wdata;
			if (i_bus_addr == `URBG_OFS_DIV_HIGH)
				div_high <= i_bus_wdata;
			// bits 7:6 are not implemented and read back as zero
			if (i_bus_addr == `URBG_OFS_DIV_FRAC)
				div_frac <= i_bus_wdata & `URBG_FRAC_STORE_MASK;
		end
	end

	// fifo control, write only, behind the divisor window
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			fifo_ctrl <= `URBG_RST_FIFO_CTRL;
		else if (wr_strobe && !i_div_latch_en && i_bus_addr == `URBG_OFS_FIFO_CTRL)
			fifo_ctrl <= i_bus_wdata;
	end

	// modem control; the strap is caught once, the cycle after reset release
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			modem_ctrl  <= `URBG_RST_MODEM_CTRL;
			strap_taken <= 1'b0;
		end
		else
		begin
			strap_taken <= 1'b1;
			if (wr_strobe && !i_div_latch_en && i_bus_addr == `URBG_OFS_MODEM_CTRL)
				modem_ctrl <= i_bus_wdata;
			else if (!strap_taken)
				modem_ctrl[`URBG_MODEM_CTRL_PRESCALE_BIT] <= i_prescale_default_select;
		end
	end

	// registered read data; unmapped offsets answer zero
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_bus_rdata <= 8'h00;
		else if (rd_strobe)
		begin
			if (i_div_latch_en && i_bus_addr == `URBG_OFS_DIV_LOW)
				o_bus_rdata <= div_low;
			else if (i_div_latch_en && i_bus_addr == `URBG_OFS_DIV_HIGH)
				o_bus_rdata <= div_high;
			else if (i_div_latch_en && i_bus_addr == `URBG_OFS_DIV_FRAC)
				o_bus_rdata <= div_frac;
			else if (!i_div_latch_en && i_bus_addr == `URBG_OFS_FIFO_CTRL)
				o_bus_rdata <= {2'h0, o_rx_timeout, rdy_state, o_pins};
			else if (!i_div_latch_en && i_bus_addr == `URBG_OFS_MODEM_CTRL)
				o_bus_rdata <= modem_ctrl;
			else
				o_bus_rdata <= 8'h00;
		end
	end

	// mode decode; block mode only changes pin behaviour, no memory is touched
	assign fifo_en  = fifo_ctrl[`URBG_FIFO_CTRL_ENABLE_BIT];
	assign block_en = fifo_en && fifo_ctrl[`URBG_FIFO_CTRL_BLOCK_BIT];
	assign o_fifo_enable = fifo_en;
	assign o_block_mode  = block_en;

	// fill level comparisons
	assign rx_has_data = (i_fifo_stat.rx_count != 6'h00);
	assign rx_at_trig  = rx_has_data && (i_fifo_stat.rx_count >= i_fifo_stat.rx_trig);
	assign tx_full     = (i_fifo_stat.tx_count >= URBG_CNT_W'(FIFO_DEPTH));

	// timeout runs only while data sits below the trigger level
	assign to_armed = fifo_en && rx_has_data && !rx_at_trig;

	// counts bit times since the last character or read; saturates at four characters
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			to_cnt <= 6'h00;
		else if (!to_armed || i_rx_char_pulse || i_rx_read_pulse)
			to_cnt <= 6'h00;
		else if (o_bit_tick && to_cnt != `URBG_TIMEOUT_BITS)
			to_cnt <= to_cnt + 6'h01;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_rx_timeout <= 1'b0;
		else
			o_rx_timeout <= to_armed && (to_cnt == `URBG_TIMEOUT_BITS);
	end

	// block mode receive ready latch: fall wins over empty in the same cycle
	always_comb
	begin
		next_rdy_state = rdy_state;
		unique case (rdy_state)
			RDY_IDLE:
				if (block_en && (rx_at_trig || o_rx_timeout))
					next_rdy_state = RDY_SET;
			RDY_SET:
				if ((!block_en || !rx_has_data) && !(block_en && (rx_at_trig || o_rx_timeout)))
					next_rdy_state = RDY_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			rdy_state <= RDY_IDLE;
		else
			rdy_state <= next_rdy_state;
	end

	// pin levels by fifo and block mode
	always_comb
	begin
		next_pins = '0;
		if (!fifo_en)
		begin
			// counts of zero or one stand for an empty or full holding register
			next_pins.tx_int     = (i_fifo_stat.tx_count == 6'h00);
			next_pins.rx_int     = rx_has_data;
			next_pins.rx_ready_n = !rx_has_data;
			next_pins.tx_ready_n = (i_fifo_stat.tx_count != 6'h00);
		end
		else if (!block_en)
		begin
			next_pins.tx_int     = (i_fifo_stat.tx_count == 6'h00);
			next_pins.rx_int     = rx_at_trig;
			next_pins.rx_ready_n = !rx_has_data;
			next_pins.tx_ready_n = (i_fifo_stat.tx_count != 6'h00);
		end
		else
		begin
			next_pins.tx_int     = (i_fifo_stat.tx_count <= i_fifo_stat.tx_trig);
			next_pins.rx_int     = rx_at_trig;
			next_pins.rx_ready_n = (next_rdy_state != RDY_SET);
			next_pins.tx_ready_n = tx_full;
		end
	end

	// pins leave flops so they never glitch; one cycle behind the fill levels
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_pins <= '{tx_int: 1'b1, rx_int: 1'b0, rx_ready_n: 1'b1, tx_ready_n: 1'b0};
		else
			o_pins <= next_pins;
	end

	// generator setup from the divisor bytes and the modem control prescale bit
	assign baud_cfg.integer_part  = {div_high, div_low};
	assign baud_cfg.fraction      = div_frac[`URBG_FRAC_MSB:`URBG_FRAC_LSB];
	assign baud_cfg.osr_sel       = div_frac[`URBG_OSR_MSB:`URBG_OSR_LSB];
	assign baud_cfg.prescale_div4 = modem_ctrl[`URBG_MODEM_CTRL_PRESCALE_BIT];

	// one sample tick drives both the shifter and the sampler
	urbg_frac_div u_div
	(
		.i_clk         (i_clk),
		.i_sys_rst     (i_sys_rst),
		.i_cfg         (baud_cfg),
		.o_sample_tick (o_sample_tick),
		.o_bit_tick    (o_bit_tick)
	);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_tx_nofifo;
		(!fifo_en && i_fifo_stat.tx_count != 6'h00) |=> !o_pins.tx_int;
	endproperty
	a_tx_nofifo: assert property (p_tx_nofifo)
		else $error("transmit interrupt high with holding register full");

	property p_tx_block_int;
		(block_en && i_fifo_stat.tx_count > i_fifo_stat.tx_trig) |=> !o_pins.tx_int;
	endproperty
	a_tx_block_int: assert property (p_tx_block_int)
		else $error("transmit interrupt high above trigger level");

	property p_rx_int;
		(fifo_en && rx_at_trig) or (!fifo_en && rx_has_data) |=> o_pins.rx_int;
	endproperty
	a_rx_int: assert property (p_rx_int)
		else $error("receive interrupt low with data at level");

	property p_rx_single;
		(!block_en && rx_has_data) |=> !o_pins.rx_ready_n;
	endproperty
	a_rx_single: assert property (p_rx_single)
		else $error("receive ready high while data held");

	property p_rx_block_fall;
		(block_en && (rx_at_trig || o_rx_timeout)) |=> !o_pins.rx_ready_n;
	endproperty
	a_rx_block_fall: assert property (p_rx_block_fall)
		else $error("receive ready did not fall at trigger or timeout");

	property p_rx_block_hold;
		(block_en && rdy_state == RDY_SET && rx_has_data) |=> !o_pins.rx_ready_n;
	endproperty
	a_rx_block_hold: assert property (p_rx_block_hold)
		else $error("receive ready rose before fifo emptied");

	property p_tx_ready_single;
		(!block_en && i_fifo_stat.tx_count == 6'h00) |=> !o_pins.tx_ready_n;
	endproperty
	a_tx_ready_single: assert property (p_tx_ready_single)
		else $error("transmit ready high with transmit side empty");

	property p_tx_ready_block;
		block_en |=> (o_pins.tx_ready_n == $past(tx_full));
	endproperty
	a_tx_ready_block: assert property (p_tx_ready_block)
		else $error("transmit ready does not match fifo full");

	property p_rst_divisor;
		$past(i_sys_rst) |-> (div_low == `URBG_RST_DIV_LOW && div_high == `URBG_RST_DIV_HIGH
		                      && div_frac == `URBG_RST_DIV_FRAC);
	endproperty
	a_rst_divisor: assert property (p_rst_divisor)
		else $error("divisor not at reset value after reset");

	property p_timeout;
		$rose(o_rx_timeout) |-> $past(to_cnt, 1) == `URBG_TIMEOUT_BITS && $past(to_armed, 1);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("receive timeout raised before four character times");

endmodule // urbg_status_baud

// [shared/urbg_consts.svh]
`ifndef URBG_CONSTS_SVH
`define URBG_CONSTS_SVH

// register offsets on the host port
`define URBG_OFS_DIV_LOW      3'h0
`define URBG_OFS_DIV_HIGH     3'h1
`define URBG_OFS_DIV_FRAC     3'h2
`define URBG_OFS_FIFO_CTRL    3'h2
`define URBG_OFS_MODEM_CTRL   3'h4

// reset values
`define URBG_RST_DIV_LOW      8'h01
`define URBG_RST_DIV_HIGH     8'h00
`define URBG_RST_DIV_FRAC     8'h00
`define URBG_RST_FIFO_CTRL    8'h00
`define URBG_RST_MODEM_CTRL   8'h00

// field positions
`define URBG_FIFO_CTRL_ENABLE_BIT    0
`define URBG_FIFO_CTRL_BLOCK_BIT     3
`define URBG_MODEM_CTRL_PRESCALE_BIT 7
`define URBG_FRAC_MSB         3
`define URBG_FRAC_LSB         0
`define URBG_OSR_MSB          5
`define URBG_OSR_LSB          4
`define URBG_FRAC_STORE_MASK  8'h3F

// oversampling select codes and sample ticks per bit
`define URBG_OSR_16X          2'h0
`define URBG_OSR_8X           2'h1
`define URBG_OSR_4X           2'h2
`define URBG_OSR_16X_TICKS    5'h10
`define URBG_OSR_8X_TICKS     5'h08
`define URBG_OSR_4X_TICKS     5'h04

// prescaler: last count of the divide-by-4 phase
`define URBG_PRESCALE_LAST    2'h3

// fractional step: one whole divisor unit in sixteenths
`define URBG_FRAC_ONE         21'h000010
`define URBG_DIV16_MIN        20'h00010

// receive timeout: four characters of ten bit times
`define URBG_TIMEOUT_BITS     6'h28

`endif

// [shared/urbg_pkg.sv]
package urbg_pkg;

	`include "urbg_consts.svh"

	localparam int URBG_CNT_W = 6;

	// dma-style receive ready latch
	typedef enum logic
	{
		RDY_IDLE = 1'b0,
		RDY_SET  = 1'b1
	} urbg_rdy_state_t;

	// fill levels reported by the channel fifos
	typedef struct packed
	{
		logic [URBG_CNT_W-1:0] tx_count;
		logic [URBG_CNT_W-1:0] rx_count;
		logic [URBG_CNT_W-1:0] tx_trig;
		logic [URBG_CNT_W-1:0] rx_trig;
	} urbg_fifo_stat_t;

	// host facing status pins
	typedef struct packed
	{
		logic tx_int;
		logic rx_int;
		logic rx_ready_n;
		logic tx_ready_n;
	} urbg_pins_t;

	// baud generator setup
	typedef struct packed
	{
		logic [15:0] integer_part;
		logic [3:0]  fraction;
		logic [1:0]  osr_sel;
		logic        prescale_div4;
	} urbg_baud_cfg_t;

	// sample ticks per bit; the unused code falls back to 16x
	function automatic logic [4:0] urbg_osr_ticks(input logic [1:0] sel);
		logic [4:0] ticks;
		ticks = `URBG_OSR_16X_TICKS;
		case (sel)
			`URBG_OSR_8X: ticks = `URBG_OSR_8X_TICKS;
			`URBG_OSR_4X: ticks = `URBG_OSR_4X_TICKS;
			default:      ticks = `URBG_OSR_16X_TICKS;
		endcase
		return ticks;
	endfunction

endpackage

// [verif/urbg_host_model.sv]
`timescale 1ns/1ns
`include "urbg_consts.svh"

module urbg_host_model
(
	// clock
	input  wire logic       i_clk,
	// register port toward the channel
	output logic            o_bus_cs,
	output logic            o_bus_wr,
	output logic            o_bus_rd,
	output logic [2:0]      o_bus_addr,
	output logic [7:0]      o_bus_wdata,
	output logic            o_div_latch_en,
	input  wire logic [7:0] i_bus_rdata
);
	// idle bus before the first access
	initial
	begin
		o_bus_cs = 1'b0;
		o_bus_wr = 1'b0;
		o_bus_rd = 1'b0;
		o_bus_addr = 3'h0;
		o_bus_wdata = 8'h5A;
		o_div_latch_en = 1'b0;
	end

	// launch after an edge, hold through the taking edge, then release
	task automatic access(input logic w, input logic [2:0] a, input logic l, input logic [7:0] d);
		@(posedge i_clk);
		o_bus_cs <= 1'b1;
		o_bus_wr <= w;
		o_bus_rd <= ~w;
		o_bus_addr <= a;
		o_div_latch_en <= l;
		o_bus_wdata <= d;
		@(posedge i_clk);
		o_bus_cs <= 1'b0;
		o_bus_wr <= 1'b0;
		o_bus_rd <= 1'b0;
		o_bus_wdata <= ~d; // released data must not look valid
	endtask

	task automatic write_reg(input logic [2:0] a, input logic l, input logic [7:0] d);
		access(1'b1, a, l, d);
	endtask

	// read data is registered at the taking edge and sampled one cycle later
	task automatic read_reg(input logic [2:0] a, input logic l, output logic [7:0] d);
		access(1'b0, a, l, 8'h00);
		@(posedge i_clk);
		#1;
		d = i_bus_rdata;
	endtask

	// divisor bytes come from the integer part, the sixteenths and the oversampling select
	task automatic set_divisor(input logic [15:0] ip, input logic [3:0] fr, input logic [1:0] osr);
		write_reg(`URBG_OFS_DIV_HIGH, 1'b1, ip[15:8]);
		write_reg(`URBG_OFS_DIV_LOW, 1'b1, ip[7:0]);
		write_reg(`URBG_OFS_DIV_FRAC, 1'b1, {2'h0, osr, fr});
	endtask
endmodule // urbg_host_model

// [verif/urbg_status_baud_tb.sv]
`timescale 1ns/1ns
`include "urbg_consts.svh"

module urbg_status_baud_tb
	import urbg_pkg::*;
;
	// fifo ctrl, tx count, rx count, tx trig, rx trig, expected pins
	localparam logic [35:0] PIN_ROWS [9] = '{
		{8'h00, 6'h01, 6'h00, 6'h00, 6'h00, 4'h3},
		{8'h00, 6'h00, 6'h01, 6'h00, 6'h00, 4'hC},
		{8'h01, 6'h00, 6'h03, 6'h08, 6'h08, 4'h8},
		{8'h01, 6'h05, 6'h08, 6'h08, 6'h08, 4'h5},
		{8'h09, 6'h09, 6'h00, 6'h08, 6'h08, 4'h2},
		{8'h09, 6'h08, 6'h03, 6'h08, 6'h08, 4'hA},
		{8'h09, 6'h20, 6'h08, 6'h08, 6'h08, 4'h5},
		{8'h09, 6'h1F, 6'h03, 6'h08, 6'h08, 4'h0},
		{8'h09, 6'h00, 6'h00, 6'h08, 6'h08, 4'hA}};
	// integer, fraction, osr, modem ctrl, cycles per bit, samples per bit
	localparam logic [53:0] BAUD_ROWS [7] = '{
		{16'h0001, 4'h0, 2'h0, 8'h00, 16'h0010, 8'h10},
		{16'h0003, 4'h0, 2'h1, 8'h00, 16'h0018, 8'h08},
		{16'h0002, 4'h8, 2'h0, 8'h00, 16'h0028, 8'h10},
		{16'h0005, 4'h0, 2'h2, 8'h00, 16'h0014, 8'h04},
		{16'h0001, 4'h0, 2'h2, 8'h80, 16'h0010, 8'h04},
		{16'h0100, 4'h0, 2'h2, 8'h00, 16'h0400, 8'h04},
		{16'h0001, 4'h0, 2'h3, 8'h00, 16'h0010, 8'h10}};

	// stimulus and observed signals
	logic            clk;
	logic            rst;
	logic            strap;
	logic            read_p;
	logic            char_p;
	urbg_fifo_stat_t stat;
	urbg_pins_t      pins;
	logic            rx_to;
	logic            fen;
	logic            blk;
	logic            stick;
	logic            btick;
	logic [7:0]      rdata;
	logic            cs;
	logic            wr;
	logic            rd;
	logic [2:0]      addr;
	logic [7:0]      wdata;
	logic            latch;
	int              errors = 0;
	int              n_compared = 0;

	always #20 clk = ~clk;

	urbg_host_model i_urbg_host_model (.i_clk(clk), .o_bus_cs(cs), .o_bus_wr(wr), .o_bus_rd(rd),
		.o_bus_addr(addr), .o_bus_wdata(wdata), .o_div_latch_en(latch), .i_bus_rdata(rdata));

	urbg_status_baud i_urbg_status_baud (.i_clk(clk), .i_sys_rst(rst), .i_bus_cs(cs),
		.i_bus_wr(wr), .i_bus_rd(rd), .i_bus_addr(addr), .i_bus_wdata(wdata),
		.i_div_latch_en(latch), .o_bus_rdata(rdata), .i_prescale_default_select(strap),
		.i_fifo_stat(stat), .i_rx_char_pulse(char_p), .i_rx_read_pulse(read_p), .o_pins(pins),
		.o_rx_timeout(rx_to), .o_fifo_enable(fen), .o_block_mode(blk),
		.o_sample_tick(stick), .o_bit_tick(btick));

	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t byte got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t flag got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chk_count(input int got, input int exp);
		n_compared++;
		if (got != exp)
		begin
			errors++;
			$display("BAD %0t count got %0d exp %0d", $time, got, exp);
		end
	endtask

	// pins follow fill levels one cycle late; look two cycles on
	task automatic set_stat(input logic [23:0] s);
		@(posedge clk);
		stat <= s;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// third bit interval, so a divisor change has settled
	task automatic measure(output int cyc, output int smp);
		int k;
		for (k = 0; k < 3; k++)
		begin
			cyc = 0;
			smp = 0;
			do
			begin
				@(negedge clk);
				cyc++;
				smp += (stick === 1'b1);
			end while (btick !== 1'b1 && cyc < 5000);
			if (cyc >= 5000)
			begin
				errors++;
				$display("BAD %0t no bit tick", $time);
				give_verdict();
			end
		end
	endtask

	// bounded wait for the receive timeout; a miss counts as a mismatch
	task automatic wait_timeout(input int lim);
		int k;
		for (k = 0; k < lim && rx_to !== 1'b1; k++)
			@(negedge clk);
		if (k == lim)
		begin
			errors++;
			$display("BAD %0t no receive timeout", $time);
			give_verdict();
		end
	endtask

	// main sequence
	initial
	begin
		int k;
		int cyc;
		int smp;
		logic [7:0] d;
		logic [35:0] pr;
		logic [53:0] br;
		clk = 1'b0;
		rst = 1'b1;
		strap = 1'b1;
		read_p = 1'b0;
		char_p = 1'b0;
		stat = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		measure(cyc, smp);
		chk_count(cyc, 64);
		i_urbg_host_model.read_reg(`URBG_OFS_MODEM_CTRL, 1'b0, d);
		chk_byte(d, 8'h80);
		i_urbg_host_model.read_reg(`URBG_OFS_DIV_LOW, 1'b1, d);
		chk_byte(d, 8'h01);
		i_urbg_host_model.read_reg(`URBG_OFS_DIV_HIGH, 1'b1, d);
		chk_byte(d, 8'h00);
		i_urbg_host_model.read_reg(`URBG_OFS_DIV_FRAC, 1'b1, d);
		chk_byte(d, 8'h00);
		i_urbg_host_model.set_divisor(16'hABCD, 4'hF, 2'h3);
		i_urbg_host_model.write_reg(`URBG_OFS_DIV_FRAC, 1'b1, 8'hFF);
		i_urbg_host_model.read_reg(`URBG_OFS_DIV_HIGH, 1'b1, d);
		chk_byte(d, 8'hAB);
		i_urbg_host_model.read_reg(`URBG_OFS_DIV_LOW, 1'b1, d);
		chk_byte(d, 8'hCD);
		i_urbg_host_model.read_reg(`URBG_OFS_DIV_FRAC, 1'b1, d);
		chk_byte(d, 8'h3F);
		i_urbg_host_model.read_reg(3'h7, 1'b1, d);
		chk_byte(d, 8'h00);
		// pin levels across fifo off, single and block modes
		for (k = 0; k < 9; k++)
		begin
			pr = PIN_ROWS[k];
			i_urbg_host_model.write_reg(`URBG_OFS_FIFO_CTRL, 1'b0, pr[35:28]);
			set_stat(pr[27:4]);
			chk_byte({4'h0, pins}, {4'h0, pr[3:0]});
			chk_bit(fen, pr[28]);
			chk_bit(blk, pr[28] & pr[31]);
		end
		// baud generator rates
		for (k = 0; k < 7; k++)
		begin
			br = BAUD_ROWS[k];
			i_urbg_host_model.set_divisor(br[53:38], br[37:34], br[33:32]);
			i_urbg_host_model.write_reg(`URBG_OFS_MODEM_CTRL, 1'b0, br[31:24]);
			measure(cyc, smp);
			chk_count(cyc, int'(br[23:8]));
			chk_count(smp, int'(br[7:0]));
		end
		// receive timeout in block mode, divisor one at 16x
		i_urbg_host_model.set_divisor(16'h0001, 4'h0, 2'h0);
		set_stat({6'h00, 6'h03, 6'h08, 6'h08});
		repeat (600) @(posedge clk);
		#1;
		chk_bit(rx_to, 1'b0);
		wait_timeout(100);
		repeat (2) @(negedge clk);
		chk_bit(pins.rx_ready_n, 1'b0);
		// status byte: timeout, latch set, tx_int high, rest low
		i_urbg_host_model.read_reg(`URBG_OFS_FIFO_CTRL, 1'b0, d);
		chk_byte(d, 8'h38);
		@(posedge clk);
		read_p <= 1'b1;
		@(posedge clk);
		read_p <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk_bit(rx_to, 1'b0);
		chk_bit(pins.rx_ready_n, 1'b0);
		// a new character restarts the count as well
		wait_timeout(700);
		@(posedge clk);
		char_p <= 1'b1;
		@(posedge clk);
		char_p <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk_bit(rx_to, 1'b0);
		give_verdict();
	end
endmodule // urbg_status_baud_tb
